/* File: verilog/rstsq_sequencer.sv */
// rstsq_sequencer: reset request classification and hold-off sequencing
// assumes wdt_tick pulses once per watchdog oscillator cycle, program memory answers in one cycle
`timescale 1ns/100ps
module rstsq_sequencer #(
  parameter int unsigned SYS_WDT_CYCLES   = rstsq_pkg::SYS_WDT_CYCLES,
  parameter int unsigned SHORT_WDT_CYCLES = rstsq_pkg::SHORT_WDT_CYCLES,
  parameter int unsigned SYSCLK_CYCLES    = rstsq_pkg::SYSCLK_CYCLES,
  parameter int unsigned CNT_W            = rstsq_pkg::CNT_W
) (
  input  wire logic                  core_clk,
  input  wire logic                  rst_n,
  input  wire logic                  wdt_tick,
  input  wire rstsq_pkg::rstsq_mode_t op_mode,
  input  wire logic                  por_bor,
  input  wire logic                  wdt_timeout,
  input  wire logic                  wdt_reset_en,
  input  wire logic                  ext_reset_n,
  input  wire logic                  debug_pin,
  input  wire logic [7:0]            debugger_control_register,
  input  wire logic [7:0]            pmem_rdata,
  output logic [15:0]                pmem_addr,
  output logic                       pmem_rd,
  output rstsq_pkg::rstsq_ctl_t      ctl,
  output logic [15:0]                pc_load_val,
  output logic                       pc_load,
  output logic                       short_reset_q,
  output logic                       busy
);
  rstsq_pkg::rstsq_state_t state_q;
  logic [CNT_W-1:0] cnt_q;
  logic        ext_s;
  logic        dbgpin_s;
  logic        dbg_only_q;
  logic [7:0]  vec_hi_q;
  logic        sys_req;
  logic        short_req;
  logic        any_req;
  logic        stop_mode;
  logic        promote;
  logic        cnt_last;
  logic        wdt_last;
  logic        vec_lo_due_q;

  // the counter must hold every preload; a short count longer than the system one makes no sense
  if (CNT_W < 2 || CNT_W > 16) begin : g_bad_cnt_w
    $error("counter width out of range");
  end
  if (SYS_WDT_CYCLES == 0 || SYS_WDT_CYCLES >= (1 << CNT_W)) begin : g_bad_sys_cnt
    $error("system count does not fit the counter");
  end
  if (SHORT_WDT_CYCLES == 0 || SHORT_WDT_CYCLES > SYS_WDT_CYCLES) begin : g_bad_short_cnt
    $error("short count out of range");
  end
  if (SYSCLK_CYCLES == 0 || SYSCLK_CYCLES >= (1 << CNT_W)) begin : g_bad_clk_cnt
    $error("clock count does not fit the counter");
  end

  rstsq_sync u_ext_sync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .din      (~ext_reset_n),
    .dout     (ext_s)
  );

  rstsq_sync u_dbg_sync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .din      (~debug_pin),
    .dout     (dbgpin_s)
  );

  assign stop_mode = (op_mode == rstsq_pkg::RSTSQ_MODE_STOP);

  // power-on wins over everything; debugger request is always full length
  always_comb begin
    sys_req = por_bor;
    sys_req = sys_req | debugger_control_register[rstsq_pkg::DBGCTL_RESET_BIT];
    sys_req = sys_req | (stop_mode & (ext_s | dbgpin_s));
    short_req = ~stop_mode & ((wdt_timeout & wdt_reset_en) | ext_s);
  end
  assign any_req = sys_req | short_req;

  // a full-length request arriving during a short count restarts it long
  assign promote  = sys_req & short_reset_q;
  assign cnt_last = (cnt_q == CNT_W'(1));
  assign wdt_last = wdt_tick & cnt_last & ~promote;

  // phase sequencing
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= rstsq_pkg::RSTSQ_ST_WDT;
    end else begin
      unique case (state_q)
        rstsq_pkg::RSTSQ_ST_RUN: begin
          if (any_req) begin
            state_q <= rstsq_pkg::RSTSQ_ST_WDT;
          end
        end
        rstsq_pkg::RSTSQ_ST_WDT: begin
          if (wdt_last) begin
            state_q <= rstsq_pkg::RSTSQ_ST_SYSCLK;
          end
        end
        rstsq_pkg::RSTSQ_ST_SYSCLK: begin
          if (cnt_last) begin
            state_q <= rstsq_pkg::RSTSQ_ST_FETCH_H;
          end
        end
        rstsq_pkg::RSTSQ_ST_FETCH_H: begin
          state_q <= rstsq_pkg::RSTSQ_ST_FETCH_L;
        end
        rstsq_pkg::RSTSQ_ST_FETCH_L: begin
          state_q <= rstsq_pkg::RSTSQ_ST_RUN;
        end
        default: begin
          state_q <= rstsq_pkg::RSTSQ_ST_WDT;
        end
      endcase
    end
  end

  // hold-off counter: watchdog ticks first, then system clocks
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= CNT_W'(SYS_WDT_CYCLES);
    end else if (state_q == rstsq_pkg::RSTSQ_ST_RUN) begin
      if (any_req) begin
        cnt_q <= sys_req ? CNT_W'(SYS_WDT_CYCLES)
                         : CNT_W'(SHORT_WDT_CYCLES);
      end
    end else if (state_q == rstsq_pkg::RSTSQ_ST_WDT) begin
      if (promote) begin
        cnt_q <= CNT_W'(SYS_WDT_CYCLES);
      end else if (wdt_last) begin
        cnt_q <= CNT_W'(SYSCLK_CYCLES);
      end else if (wdt_tick) begin
        cnt_q <= cnt_q - CNT_W'(1);
      end
    end else if (state_q == rstsq_pkg::RSTSQ_ST_SYSCLK) begin
      if (!cnt_last) begin
        cnt_q <= cnt_q - CNT_W'(1);
      end
    end
  end

  // reset type of the running sequence
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      short_reset_q <= 1'b0;
    end else if (state_q == rstsq_pkg::RSTSQ_ST_RUN && any_req) begin
      short_reset_q <= ~sys_req;
    end else if (state_q == rstsq_pkg::RSTSQ_ST_WDT && promote) begin
      short_reset_q <= 1'b0;
    end
  end

  // debugger survives only a debugger-initiated reset
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      dbg_only_q <= 1'b0;
    end else if (state_q == rstsq_pkg::RSTSQ_ST_RUN && any_req) begin
      dbg_only_q <= debugger_control_register[rstsq_pkg::DBGCTL_RESET_BIT] & ~por_bor;
    end else if (state_q == rstsq_pkg::RSTSQ_ST_WDT && por_bor) begin
      dbg_only_q <= 1'b0;
    end
  end

  // vector capture; memory data arrives one cycle after its read, so the low byte
  // is only there in the first run cycle and the load pulse trails the release by one
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      vec_hi_q     <= 8'h00;
      vec_lo_due_q <= 1'b0;
      pc_load_val  <= 16'h0000;
      pc_load      <= 1'b0;
    end else begin
      vec_lo_due_q <= (state_q == rstsq_pkg::RSTSQ_ST_FETCH_L);
      pc_load      <= vec_lo_due_q;
      if (state_q == rstsq_pkg::RSTSQ_ST_FETCH_L) begin
        vec_hi_q <= pmem_rdata;
      end
      if (vec_lo_due_q) begin
        pc_load_val <= {vec_hi_q, pmem_rdata};
      end
    end
  end

  always_comb begin
    pmem_rd   = (state_q == rstsq_pkg::RSTSQ_ST_FETCH_H) | (state_q == rstsq_pkg::RSTSQ_ST_FETCH_L);
    pmem_addr = (state_q == rstsq_pkg::RSTSQ_ST_FETCH_L) ? rstsq_pkg::RESET_VECTOR_LO_ADDR
                                                         : rstsq_pkg::RESET_VECTOR_HI_ADDR;
  end

  // oscillators are not gated here, only the delivered system clock; needs no logic
  always_comb begin
    ctl.core_rst   = (state_q != rstsq_pkg::RSTSQ_ST_RUN);
    ctl.periph_rst = (state_q != rstsq_pkg::RSTSQ_ST_RUN);
    ctl.dbg_rst    = (state_q == rstsq_pkg::RSTSQ_ST_WDT) & ~dbg_only_q;
    ctl.sysclk_en  = (state_q != rstsq_pkg::RSTSQ_ST_WDT);
    ctl.regs_load  = (state_q == rstsq_pkg::RSTSQ_ST_WDT) | (state_q == rstsq_pkg::RSTSQ_ST_SYSCLK);
    busy           = (state_q != rstsq_pkg::RSTSQ_ST_RUN);
  end

endmodule : rstsq_sequencer

/* File: verilog/rstsq_pkg.sv */
// rstsq_pkg: constants and types shared by the reset sequencer files
// assumes a single core_clk domain; watchdog oscillator seen as a tick input
package rstsq_pkg;

  localparam int unsigned SYS_WDT_CYCLES   = 514;
  localparam int unsigned SHORT_WDT_CYCLES = 66;
  localparam int unsigned SYSCLK_CYCLES    = 16;
  localparam int unsigned CNT_W            = 10;
  localparam logic [15:0] RESET_VECTOR_HI_ADDR = 16'h0002;
  localparam logic [15:0] RESET_VECTOR_LO_ADDR = 16'h0003;
  localparam int unsigned DBGCTL_RESET_BIT = 1;

  typedef enum logic [1:0] {
    RSTSQ_MODE_NORMAL = 2'h0,
    RSTSQ_MODE_HALT   = 2'h1,
    RSTSQ_MODE_STOP   = 2'h2
  } rstsq_mode_t;

  typedef enum logic [2:0] {
    RSTSQ_ST_RUN     = 3'h0,
    RSTSQ_ST_WDT     = 3'h1,
    RSTSQ_ST_SYSCLK  = 3'h2,
    RSTSQ_ST_FETCH_H = 3'h3,
    RSTSQ_ST_FETCH_L = 3'h4
  } rstsq_state_t;

  typedef struct packed {
    logic por_bor;
    logic wdt_timeout;
    logic ext_pin;
    logic dbg_req;
    logic dbg_pin_low;
  } rstsq_src_t;

  typedef struct packed {
    logic core_rst;
    logic periph_rst;
    logic dbg_rst;
    logic sysclk_en;
    logic regs_load;
  } rstsq_ctl_t;

endpackage : rstsq_pkg

/* File: verilog/rstsq_sync.sv */
// rstsq_sync: two-flop level synchroniser
// assumes asynchronous inputs, core_clk destination domain
`timescale 1ns/100ps
module rstsq_sync (
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic din,
  output logic      dout
);
  logic meta_q;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= 1'b0;
      dout   <= 1'b0;
    end else begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end
endmodule : rstsq_sync

/* File: verification/rstsq_chk.sv */
// rstsq_chk: port-level checks of the reset sequencer
// assumes a single core_clk domain; bound to every rstsq_sequencer
`timescale 1ns/100ps
module rstsq_chk (
  input wire logic                  core_clk,
  input wire logic                  rst_n,
  input wire logic                  wdt_tick,
  input wire logic                  por_bor,
  input wire logic [7:0]            debugger_control_register,
  input wire logic [7:0]            pmem_rdata,
  input wire logic [15:0]           pmem_addr,
  input wire logic                  pmem_rd,
  input wire rstsq_pkg::rstsq_ctl_t ctl,
  input wire logic [15:0]           pc_load_val,
  input wire logic                  pc_load,
  input wire logic                  short_reset_q,
  input wire logic                  busy
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence vec_fetch;
    (pmem_rd && pmem_addr == 16'h0002) ##1 (pmem_rd && pmem_addr == 16'h0003) ##2 pc_load;
  endsequence
  a_idle_in_reset:    assert property (busy |-> ctl.core_rst && ctl.periph_rst) else $error("core active in reset");
  a_clk_after_count:  assert property ($rose(ctl.sysclk_en) |-> $past(wdt_tick)) else $error("clock before count");
  a_fetch_after_16:   assert property ($rose(ctl.sysclk_en) |-> ##16 vec_fetch) else $error("fetch misplaced");
  a_release_loads_pc: assert property ($fell(ctl.core_rst) |=> pc_load) else $error("no pc load");
  a_vector_both_bytes: assert property (pc_load |-> pc_load_val == {$past(pmem_rdata, 2), $past(pmem_rdata)})
    else $error("bad vector");
  a_por_is_system:    assert property (por_bor && !busy |=> ctl.core_rst && !short_reset_q) else $error("por");
  // debugger request without power-on must spare the debugger itself
  a_dbg_spared: assert property (debugger_control_register[1] && !busy && !por_bor |=> !ctl.dbg_rst)
    else $error("debugger reset");
  a_regs_loaded:      assert property ($rose(ctl.core_rst) |-> ctl.regs_load) else $error("no reg load");
endmodule : rstsq_chk
bind rstsq_sequencer rstsq_chk i_rstsq_chk (.core_clk(core_clk), .rst_n(rst_n), .wdt_tick(wdt_tick),
  .por_bor(por_bor), .debugger_control_register(debugger_control_register), .pmem_rdata(pmem_rdata),
  .pmem_addr(pmem_addr), .pmem_rd(pmem_rd), .ctl(ctl), .pc_load_val(pc_load_val), .pc_load(pc_load),
  .short_reset_q(short_reset_q), .busy(busy));

/* File: verification/rstsq_partner.sv */
// rstsq_partner: watchdog oscillator ticks and program memory
// assumes one-cycle read latency; unread data toggles every cycle
`timescale 1ns/100ps
module rstsq_partner #(parameter logic [15:0] VEC = 16'h1A5C) (
  input wire logic  core_clk,
  input wire logic [15:0] pmem_addr,
  input wire logic  pmem_rd,
  output logic      wdt_tick = 1'b0,
  output logic [7:0] pmem_rdata = 8'h00
);
  logic [1:0] div_q = 2'h0;
  // watchdog oscillator never stops, even during reset
  always @(posedge core_clk) begin
    div_q <= #1 div_q + 2'h1;
    wdt_tick <= #1 (div_q == 2'h3);
    pmem_rdata <= #1 !pmem_rd ? ~pmem_rdata : pmem_addr == 16'h0002 ? VEC[15:8] :
                  pmem_addr == 16'h0003 ? VEC[7:0] : ~pmem_rdata;
  end
endmodule : rstsq_partner

/* File: verification/rstsq_sequencer_test.sv */
// rstsq_sequencer_test: scenario bench for the reset sequencer
// assumes the partner model supplies ticks and the reset vector
`timescale 1ns/100ps
module rstsq_sequencer_test;
  localparam logic [15:0] VEC = 16'h1A5C;
  localparam logic [15:0] SYS = 16'(rstsq_pkg::SYS_WDT_CYCLES);
  localparam logic [15:0] SHT = 16'(rstsq_pkg::SHORT_WDT_CYCLES);
  logic core_clk = 0, rst_n = 0, por_bor = 0, wdt_timeout = 0, wdt_reset_en = 1, ext_reset_n = 1, debug_pin = 1;
  logic wdt_tick, pmem_rd, pc_load, short_reset_q, busy;
  logic [7:0] debugger_control_register = 8'h00, pmem_rdata;
  logic [15:0] pmem_addr, pc_load_val;
  rstsq_pkg::rstsq_ctl_t ctl;
  rstsq_pkg::rstsq_mode_t op_mode = rstsq_pkg::RSTSQ_MODE_NORMAL;
  int fails = 0, n_compared = 0;
  always #25 core_clk = ~core_clk;
  rstsq_partner #(.VEC(VEC)) i_rstsq_partner (.core_clk(core_clk), .pmem_addr(pmem_addr), .pmem_rd(pmem_rd),
    .wdt_tick(wdt_tick), .pmem_rdata(pmem_rdata));
  rstsq_sequencer i_rstsq_sequencer (.core_clk(core_clk), .rst_n(rst_n), .wdt_tick(wdt_tick), .op_mode(op_mode),
    .por_bor(por_bor), .wdt_timeout(wdt_timeout), .wdt_reset_en(wdt_reset_en), .ext_reset_n(ext_reset_n),
    .debug_pin(debug_pin), .debugger_control_register(debugger_control_register), .pmem_rdata(pmem_rdata),
    .pmem_addr(pmem_addr), .pmem_rd(pmem_rd), .ctl(ctl), .pc_load_val(pc_load_val), .pc_load(pc_load),
    .short_reset_q(short_reset_q), .busy(busy));
  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // bits: por, watchdog, reset pin, debug pin, debugger; pins are active low
  task req(input logic [4:0] r, input int hold);
    @(posedge core_clk) #5;
    {por_bor, wdt_timeout, ext_reset_n, debug_pin, debugger_control_register[1]} = r ^ 5'h06;
    repeat (hold) @(posedge core_clk);
    #5 {por_bor, wdt_timeout, ext_reset_n, debug_pin, debugger_control_register[1]} = 5'h06;
  endtask : req
  // ticks counted only in the watchdog phase, clocks only before the fetch
  task measure(input logic [15:0] ticks, input logic sh, input logic dbg);
    logic [15:0] t, c;
    logic s, d;
    t = 0; c = 0; s = 1'bx; d = 1'bx;
    for (int n = 0; n < 6000 && pc_load !== 1'b1; n++) begin
      @(negedge core_clk);
      if (ctl.core_rst && !ctl.sysclk_en) begin
        d = ctl.dbg_rst;
        if (wdt_tick) t++;
      end
      if (ctl.core_rst && ctl.sysclk_en && !pmem_rd) begin
        c++; s = short_reset_q;
      end
    end
    chk(pc_load, 1); chk(t, ticks); chk(c, 16'(rstsq_pkg::SYSCLK_CYCLES)); chk(s, sh); chk(d, dbg);
    chk(pc_load_val, VEC);
    @(posedge core_clk) #5 chk(busy, 0);
  endtask : measure
  task t_power_up;
    measure(SYS, 0, 1);
    $display("done power_up");
  endtask : t_power_up
  task t_wdt_short;
    req(5'h08, 1); measure(SHT, 1, 1);
    $display("done wdt_short");
  endtask : t_wdt_short
  task t_pin_short;
    op_mode = rstsq_pkg::RSTSQ_MODE_HALT;
    req(5'h04, 3); measure(SHT, 1, 1);
    $display("done pin_short");
  endtask : t_pin_short
  task t_por_wins;
    req(5'h1C, 1); measure(SYS, 0, 1);
    $display("done por_wins");
  endtask : t_por_wins
  task t_debugger;
    op_mode = rstsq_pkg::RSTSQ_MODE_NORMAL;
    req(5'h01, 1); measure(SYS, 0, 0);
    $display("done debugger");
  endtask : t_debugger
  task t_stop;
    op_mode = rstsq_pkg::RSTSQ_MODE_STOP;
    req(5'h08, 1); repeat (8) @(posedge core_clk); #5 chk(busy, 0);
    req(5'h04, 3); measure(SYS, 0, 1);
    req(5'h02, 3); measure(SYS, 0, 1);
    $display("done stop");
  endtask : t_stop
  task complete_run;
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : complete_run
  initial begin
    repeat (5) @(posedge core_clk);
    #5 rst_n = 1;
    t_power_up; t_wdt_short; t_pin_short; t_por_wins; t_debugger; t_stop;
    complete_run;
  end
  // five system and two short sequences need about 11000 cycles
  initial begin
    #(25000 * 50);
    fails++;
    complete_run;
  end
endmodule : rstsq_sequencer_test
